// ===== aau_adder.sv
// Purpose: 56-bit adder with carry in, carry out and signed overflow
// Assumes: combinational, used inside the accumulator unit
// Notes: carry is the unsigned carry out of the top bit
`timescale 1ns/1ps
`include "aau_map.svh"
module aau_adder
   import aau_pkg::*;
(
   input wire logic [`AAU_ACC_W-1:0] a_in,
   input wire logic [`AAU_ACC_W-1:0] b_in,
   input wire logic cin_in,
   output aau_sum_t sum_out
);
   logic [`AAU_ACC_W:0] wide;

   always_comb begin
      wide = {1'b0, a_in} + {1'b0, b_in} + {{`AAU_ACC_W{1'b0}}, cin_in};
      sum_out.sum = wide[`AAU_ACC_W-1:0];
      sum_out.carry = wide[`AAU_ACC_W];
      sum_out.ovf = (a_in[`AAU_MSB] == b_in[`AAU_MSB]) &&
                    (wide[`AAU_MSB] != a_in[`AAU_MSB]);
   end
endmodule : aau_adder

// ===== aau_core_model.sv
// Purpose: core decoder model issuing opcode words
// Assumes: one issue call at a time
// Notes: released word lines carry the inverse word
`timescale 1ns/1ps
`include "aau_map.svh"
module aau_core_model
   import aau_pkg::*;
(
   input wire logic mclk_in,
   input wire logic instr_ready_in,
   input wire logic ext_ready_in,
   input wire logic done_in,
   input wire logic illegal_in,
   output logic instr_valid_out,
   output logic [`AAU_WORD_W-1:0] instr_word_out,
   output logic ext_valid_out,
   output logic [`AAU_WORD_W-1:0] ext_word_out
);
   initial {instr_valid_out, instr_word_out, ext_valid_out, ext_word_out} = '0;
   task automatic issue(input logic [23:0] w, input logic [23:0] e, output logic ok);
      int n;
      @(posedge mclk_in);
      {instr_valid_out, instr_word_out} <= {1'b1, w};
      n = 0;
      @(posedge mclk_in);
      while (instr_ready_in !== 1'b1 && n < 50) begin
         @(posedge mclk_in);
         n++;
      end
      {instr_valid_out, instr_word_out} <= {1'b0, ~w};
      if ((w & `AAU_ADDI_MASK) == `AAU_ADDI_MATCH) begin
         {ext_valid_out, ext_word_out} <= {1'b1, e};
         @(posedge mclk_in);
         while (ext_ready_in !== 1'b1 && n < 50) begin
            @(posedge mclk_in);
            n++;
         end
         {ext_valid_out, ext_word_out} <= {1'b0, ~e};
      end
      @(posedge mclk_in);
      while (done_in !== 1'b1 && illegal_in !== 1'b1 && n < 50) begin
         @(posedge mclk_in);
         n++;
      end
      ok = n < 50;
   endtask : issue
endmodule : aau_core_model

// ===== aau_decode.sv
// Purpose: opcode recognition for the accumulator unit
// Assumes: bits 23 to 8 of register forms belong to the parallel move logic
// Notes: selector code zero of the register add is treated as illegal
`timescale 1ns/1ps
`include "aau_map.svh"
module aau_decode
   import aau_pkg::*;
(
   input wire logic [`AAU_WORD_W-1:0] word_in,
   output aau_op_t op_out
);
   always_comb begin
      op_out.kind = KIND_ILLEGAL;
      op_out.dest_b = word_in[`AAU_BIT_D];
      op_out.src_y = word_in[`AAU_BIT_J];
      op_out.source_selector_field = word_in[`AAU_SEL_HI:`AAU_SEL_LO];
      op_out.imm = word_in[`AAU_IMM_HI:`AAU_IMM_LO];
      if ((word_in & `AAU_ADDI_MASK) == `AAU_ADDI_MATCH) begin
         op_out.kind = KIND_ADD_LONG;
      end else if ((word_in & `AAU_ADDS_MASK) == `AAU_ADDS_MATCH) begin
         op_out.kind = KIND_ADD_SHORT;
      end else if ((word_in & `AAU_MAG_MASK) == `AAU_MAG_MATCH) begin
         op_out.kind = KIND_MAGNITUDE;
      end else if ((word_in & `AAU_ADC_MASK) == `AAU_ADC_MATCH) begin
         op_out.kind = KIND_ADD_CARRY;
      end else if ((word_in & `AAU_SHL_MASK) == `AAU_SHL_MATCH) begin
         op_out.kind = KIND_SHL_SUM;
      end else if ((word_in & `AAU_ADDR_MASK) == `AAU_ADDR_MATCH &&
                   word_in[`AAU_SEL_HI:`AAU_SEL_LO] != 3'h0) begin
         op_out.kind = KIND_ADD_REG;
      end
   end
endmodule : aau_decode

// ===== aau_map.svh
// Purpose: offsets, field positions, opcode patterns and widths for the accumulator unit
// Assumes: included by bare name from the package and the design modules
// Notes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
`ifndef AAU_MAP_SVH
`define AAU_MAP_SVH

`define AAU_ACC_W 56
`define AAU_LONG_W 48
`define AAU_WORD_W 24
`define AAU_EXT_W 8
`define AAU_MSB 55
`define AAU_LONG_MSB 47
`define AAU_ADDR_W 5
`define AAU_DATA_W 32
`define AAU_LANES 4
`define AAU_LANE_W 8
`define AAU_ACC_ONE 56'h1

// register offsets
`define AAU_OFF_ACC_A_LOW 5'h00
`define AAU_OFF_ACC_A_MIDDLE_WORD 5'h04
`define AAU_OFF_ACC_A_EXTENSION 5'h08
`define AAU_OFF_ACC_B_LOW 5'h0c
`define AAU_OFF_ACC_B_MIDDLE_WORD 5'h10
`define AAU_OFF_ACC_B_EXTENSION 5'h14
`define AAU_OFF_CONDITION_FLAGS 5'h18
`define AAU_OFF_STATUS 5'h1c

// condition flag bit positions
`define AAU_FLAG_C 0
`define AAU_FLAG_V 1
`define AAU_FLAG_Z 2
`define AAU_FLAG_N 3
`define AAU_FLAG_U 4
`define AAU_FLAG_E 5
`define AAU_FLAG_L 6
`define AAU_FLAG_S 7

// status bit positions
`define AAU_STAT_EXT_PENDING 0
`define AAU_STAT_LAST_ILLEGAL 1

// reset values
`define AAU_FLAGS_RST 8'h00
`define AAU_ACC_RST 56'h0

// opcode mask and match pairs
`define AAU_MAG_MASK 24'h0000f7
`define AAU_MAG_MATCH 24'h000026
`define AAU_ADC_MASK 24'h0000e7
`define AAU_ADC_MATCH 24'h000021
`define AAU_SHL_MASK 24'h0000f7
`define AAU_SHL_MATCH 24'h000012
`define AAU_ADDR_MASK 24'h000087
`define AAU_ADDR_MATCH 24'h000000
`define AAU_ADDS_MASK 24'hffc0f7
`define AAU_ADDS_MATCH 24'h014080
`define AAU_ADDI_MASK 24'hfffff7
`define AAU_ADDI_MATCH 24'h0140c0

// opcode field positions
`define AAU_BIT_D 3
`define AAU_BIT_J 4
`define AAU_SEL_HI 6
`define AAU_SEL_LO 4
`define AAU_IMM_HI 13
`define AAU_IMM_LO 8

// source selector codes
`define AAU_SEL_OTHER 3'h1
`define AAU_SEL_X 3'h2
`define AAU_SEL_Y 3'h3
`define AAU_SEL_X0 3'h4
`define AAU_SEL_Y0 3'h5
`define AAU_SEL_X1 3'h6
`define AAU_SEL_Y1 3'h7

`endif

// ===== aau_pkg.sv
// Purpose: types shared by the accumulator unit modules
// Assumes: aau_map.svh holds all numeric constants
// Notes: none
`include "aau_map.svh"
package aau_pkg;

   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXT = 1'b1} aau_state_t;

   typedef enum logic [2:0] {
      KIND_ILLEGAL = 3'h0,
      KIND_MAGNITUDE = 3'h1,
      KIND_ADD_CARRY = 3'h2,
      KIND_ADD_REG = 3'h3,
      KIND_ADD_SHORT = 3'h4,
      KIND_ADD_LONG = 3'h5,
      KIND_SHL_SUM = 3'h6
   } aau_kind_t;

   typedef struct packed {
      aau_kind_t kind;
      logic dest_b;
      logic src_y;
      logic [2:0] source_selector_field;
      logic [5:0] imm;
   } aau_op_t;

   typedef struct packed {
      logic [`AAU_ACC_W-1:0] sum;
      logic carry;
      logic ovf;
   } aau_sum_t;

endpackage : aau_pkg

// ===== aau_top.sv
// Purpose: accumulator add and magnitude unit with Avalon-MM register access
// Assumes: opcode and extension words come from the core decoder, X and Y from input regs
// Notes: one instruction or one bus access completes per edge, never both
`timescale 1ns/1ps
`include "aau_map.svh"
module aau_top
   import aau_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic instr_valid_in,
   input wire logic [`AAU_WORD_W-1:0] instr_word_in,
   input wire logic ext_valid_in,
   input wire logic [`AAU_WORD_W-1:0] ext_word_in,
   input wire logic [`AAU_LONG_W-1:0] x_in,
   input wire logic [`AAU_LONG_W-1:0] y_in,
   input wire logic [`AAU_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [`AAU_DATA_W-1:0] avs_writedata_in,
   input wire logic [`AAU_LANES-1:0] avs_byteenable_in,
   output logic [`AAU_DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic instr_ready_out,
   output logic ext_ready_out,
   output logic done_out,
   output logic illegal_out,
   output logic [`AAU_EXT_W-1:0] flags_out
);
   aau_state_t state, next_state;
   aau_op_t dec_op, held_op, next_held_op, exec_op;
   aau_sum_t sum;
   logic [`AAU_ACC_W-1:0] acc_a, acc_b, next_acc_a, next_acc_b;
   logic [`AAU_ACC_W-1:0] dst, oth, add_a, add_b, xy_long;
   logic [`AAU_EXT_W-1:0] condition_flags_reg, next_flags, exec_flags;
   logic add_c, fire, exec_go, last_illegal, next_last_illegal;
   logic next_done, next_illegal, next_ready, next_ext_ready;
   logic wait_q, next_wait, grant, bus_wr_go;
   logic [`AAU_DATA_W-1:0] next_rdata, wr_word;

   function automatic logic [`AAU_ACC_W-1:0] word_to_acc(input logic [`AAU_WORD_W-1:0] w);
      return {{`AAU_EXT_W{w[`AAU_WORD_W-1]}}, w, {`AAU_WORD_W{1'b0}}};
   endfunction : word_to_acc

   function automatic logic [`AAU_ACC_W-1:0] long_to_acc(input logic [`AAU_LONG_W-1:0] l);
      return {{`AAU_EXT_W{l[`AAU_LONG_MSB]}}, l};
   endfunction : long_to_acc

   function automatic logic [`AAU_DATA_W-1:0] merge(input logic [`AAU_DATA_W-1:0] old,
                                                    input logic [`AAU_DATA_W-1:0] wd,
                                                    input logic [`AAU_LANES-1:0] be);
      logic [`AAU_DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < `AAU_LANES; i++) begin
         if (be[i]) begin
            r[i*`AAU_LANE_W +: `AAU_LANE_W] = wd[i*`AAU_LANE_W +: `AAU_LANE_W];
         end
      end
      return r;
   endfunction : merge

   aau_decode u_decode (
      .word_in(instr_word_in),
      .op_out(dec_op)
   );

   aau_adder u_adder (
      .a_in(add_a),
      .b_in(add_b),
      .cin_in(add_c),
      .sum_out(sum)
   );

   // operand selection and flag computation
   always_comb begin
      exec_op = (state == ST_EXT) ? held_op : dec_op;
      dst = exec_op.dest_b ? acc_b : acc_a;
      oth = exec_op.dest_b ? acc_a : acc_b;
      xy_long = long_to_acc(exec_op.src_y ? y_in : x_in);
      add_a = dst;
      add_b = '0;
      add_c = 1'b0;
      case (exec_op.kind)
         KIND_MAGNITUDE: begin
            add_a = '0;
            add_b = dst[`AAU_MSB] ? ~dst : dst;
            add_c = dst[`AAU_MSB];
         end
         KIND_ADD_CARRY: begin
            add_b = xy_long;
            add_c = condition_flags_reg[`AAU_FLAG_C];
         end
         KIND_ADD_REG: begin
            case (exec_op.source_selector_field)
               `AAU_SEL_OTHER: add_b = oth;
               `AAU_SEL_X: add_b = long_to_acc(x_in);
               `AAU_SEL_Y: add_b = long_to_acc(y_in);
               `AAU_SEL_X0: add_b = word_to_acc(x_in[`AAU_WORD_W-1:0]);
               `AAU_SEL_Y0: add_b = word_to_acc(y_in[`AAU_WORD_W-1:0]);
               `AAU_SEL_X1: add_b = word_to_acc(x_in[`AAU_LONG_W-1:`AAU_WORD_W]);
               `AAU_SEL_Y1: add_b = word_to_acc(y_in[`AAU_LONG_W-1:`AAU_WORD_W]);
               default: add_b = '0;
            endcase
         end
         KIND_ADD_SHORT: add_b = word_to_acc({{(`AAU_WORD_W-6){1'b0}}, exec_op.imm});
         KIND_ADD_LONG: add_b = word_to_acc(ext_word_in);
         KIND_SHL_SUM: begin
            add_a = {dst[`AAU_MSB-1:0], 1'b0};
            add_b = oth;
         end
         default: add_b = '0;
      endcase
      exec_flags = condition_flags_reg;
      exec_flags[`AAU_FLAG_N] = sum.sum[`AAU_MSB];
      exec_flags[`AAU_FLAG_Z] = (sum.sum == '0);
      exec_flags[`AAU_FLAG_E] = ~((&sum.sum[`AAU_MSB:`AAU_LONG_MSB]) |
                                  ~(|sum.sum[`AAU_MSB:`AAU_LONG_MSB]));
      exec_flags[`AAU_FLAG_U] = ~(sum.sum[`AAU_LONG_MSB] ^ sum.sum[`AAU_LONG_MSB-1]);
      exec_flags[`AAU_FLAG_V] = sum.ovf |
         ((exec_op.kind == KIND_SHL_SUM) && (dst[`AAU_MSB] ^ dst[`AAU_MSB-1]));
      exec_flags[`AAU_FLAG_L] = condition_flags_reg[`AAU_FLAG_L] | exec_flags[`AAU_FLAG_V];
      if (exec_op.kind != KIND_MAGNITUDE) begin
         exec_flags[`AAU_FLAG_C] = sum.carry;
      end
   end

   // instruction sequencing and accumulator update
   always_comb begin
      fire = instr_ready_out && instr_valid_in;
      next_state = state;
      next_held_op = held_op;
      next_done = 1'b0;
      next_illegal = 1'b0;
      next_last_illegal = last_illegal;
      exec_go = 1'b0;
      case (state)
         ST_IDLE: begin
            if (fire && dec_op.kind == KIND_ILLEGAL) begin
               next_illegal = 1'b1;
               next_last_illegal = 1'b1;
            end else if (fire && dec_op.kind == KIND_ADD_LONG) begin
               next_state = ST_EXT;
               next_held_op = dec_op;
            end else if (fire) begin
               exec_go = 1'b1;
            end
         end
         ST_EXT: begin
            if (ext_valid_in) begin
               exec_go = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_acc_a = acc_a;
      next_acc_b = acc_b;
      next_flags = condition_flags_reg;
      wr_word = '0;
      if (exec_go) begin
         next_done = 1'b1;
         next_last_illegal = 1'b0;
         next_flags = exec_flags;
         if (exec_op.dest_b) begin
            next_acc_b = sum.sum;
         end else begin
            next_acc_a = sum.sum;
         end
      end else if (bus_wr_go) begin
         case (avs_address_in)
            `AAU_OFF_ACC_A_LOW: begin
               wr_word = merge({8'h0, acc_a[`AAU_WORD_W-1:0]}, avs_writedata_in, avs_byteenable_in);
               next_acc_a[`AAU_WORD_W-1:0] = wr_word[`AAU_WORD_W-1:0];
            end
            `AAU_OFF_ACC_A_MIDDLE_WORD: begin
               wr_word = merge({8'h0, acc_a[`AAU_LONG_W-1:`AAU_WORD_W]}, avs_writedata_in,
                               avs_byteenable_in);
               next_acc_a[`AAU_LONG_W-1:`AAU_WORD_W] = wr_word[`AAU_WORD_W-1:0];
            end
            `AAU_OFF_ACC_A_EXTENSION: begin
               if (avs_byteenable_in[0]) next_acc_a[`AAU_MSB:`AAU_LONG_W] = avs_writedata_in[7:0];
            end
            `AAU_OFF_ACC_B_LOW: begin
               wr_word = merge({8'h0, acc_b[`AAU_WORD_W-1:0]}, avs_writedata_in, avs_byteenable_in);
               next_acc_b[`AAU_WORD_W-1:0] = wr_word[`AAU_WORD_W-1:0];
            end
            `AAU_OFF_ACC_B_MIDDLE_WORD: begin
               wr_word = merge({8'h0, acc_b[`AAU_LONG_W-1:`AAU_WORD_W]}, avs_writedata_in,
                               avs_byteenable_in);
               next_acc_b[`AAU_LONG_W-1:`AAU_WORD_W] = wr_word[`AAU_WORD_W-1:0];
            end
            `AAU_OFF_ACC_B_EXTENSION: begin
               if (avs_byteenable_in[0]) next_acc_b[`AAU_MSB:`AAU_LONG_W] = avs_writedata_in[7:0];
            end
            `AAU_OFF_CONDITION_FLAGS: begin
               if (avs_byteenable_in[0]) next_flags = avs_writedata_in[7:0];
            end
            default: wr_word = '0;
         endcase
      end
   end

   // bus slave: grant one cycle after request, only when no instruction moves
   always_comb begin
      bus_wr_go = avs_write_in && !wait_q;
      grant = (avs_read_in || avs_write_in) && wait_q && !fire && (state == ST_IDLE);
      next_wait = !grant;
      next_ready = (next_state == ST_IDLE) && next_wait;
      next_ext_ready = (next_state == ST_EXT);
      next_rdata = avs_readdata_out;
      if (grant) begin
         next_rdata = '0;
         case (avs_address_in)
            `AAU_OFF_ACC_A_LOW: next_rdata[`AAU_WORD_W-1:0] = acc_a[`AAU_WORD_W-1:0];
            `AAU_OFF_ACC_A_MIDDLE_WORD:
               next_rdata[`AAU_WORD_W-1:0] = acc_a[`AAU_LONG_W-1:`AAU_WORD_W];
            `AAU_OFF_ACC_A_EXTENSION: next_rdata[`AAU_EXT_W-1:0] = acc_a[`AAU_MSB:`AAU_LONG_W];
            `AAU_OFF_ACC_B_LOW: next_rdata[`AAU_WORD_W-1:0] = acc_b[`AAU_WORD_W-1:0];
            `AAU_OFF_ACC_B_MIDDLE_WORD:
               next_rdata[`AAU_WORD_W-1:0] = acc_b[`AAU_LONG_W-1:`AAU_WORD_W];
            `AAU_OFF_ACC_B_EXTENSION: next_rdata[`AAU_EXT_W-1:0] = acc_b[`AAU_MSB:`AAU_LONG_W];
            `AAU_OFF_CONDITION_FLAGS: next_rdata[`AAU_EXT_W-1:0] = condition_flags_reg;
            `AAU_OFF_STATUS: begin
               next_rdata[`AAU_STAT_EXT_PENDING] = (state == ST_EXT);
               next_rdata[`AAU_STAT_LAST_ILLEGAL] = last_illegal;
            end
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         held_op <= '0;
         acc_a <= `AAU_ACC_RST;
         acc_b <= `AAU_ACC_RST;
         condition_flags_reg <= `AAU_FLAGS_RST;
         last_illegal <= 1'b0;
         done_out <= 1'b0;
         illegal_out <= 1'b0;
         flags_out <= `AAU_FLAGS_RST;
         wait_q <= 1'b1;
         avs_readdata_out <= '0;
         instr_ready_out <= 1'b1;
         ext_ready_out <= 1'b0;
      end else begin
         state <= next_state;
         held_op <= next_held_op;
         acc_a <= next_acc_a;
         acc_b <= next_acc_b;
         condition_flags_reg <= next_flags;
         last_illegal <= next_last_illegal;
         done_out <= next_done;
         illegal_out <= next_illegal;
         flags_out <= next_flags;
         wait_q <= next_wait;
         avs_readdata_out <= next_rdata;
         instr_ready_out <= next_ready;
         ext_ready_out <= next_ext_ready;
      end
   end

   assign avs_waitrequest_out = wait_q;

   // checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   logic [`AAU_LONG_W:0] chk_c48;
   logic [`AAU_ACC_W:0] chk_ab;
   assign chk_c48 = {1'b0, acc_a[`AAU_LONG_W-1:0]} + {1'b0, x_in}
                    + {{`AAU_LONG_W{1'b0}}, condition_flags_reg[`AAU_FLAG_C]};
   assign chk_ab = {1'b0, acc_a} + {1'b0, acc_b};

   sequence s_issue_long;
      instr_ready_out && instr_valid_in &&
      ((instr_word_in & `AAU_ADDI_MASK) == `AAU_ADDI_MATCH);
   endsequence
   sequence s_ext_taken_a;
      ext_ready_out && ext_valid_in && !held_op.dest_b;
   endsequence

   a_mag_value: assert property (
      (exec_go && exec_op.kind == KIND_MAGNITUDE && !exec_op.dest_b) |=>
      acc_a == ($past(acc_a[`AAU_MSB]) ? (~$past(acc_a) + `AAU_ACC_ONE) : $past(acc_a)))
      else $error("magnitude result wrong");
   a_mag_decode: assert property (
      (instr_ready_out && instr_valid_in &&
       ((instr_word_in & `AAU_MAG_MASK) == `AAU_MAG_MATCH)) |=> done_out && !illegal_out)
      else $error("magnitude opcode not executed");
   a_adc_sum_a: assert property (
      (instr_ready_out && instr_valid_in && instr_word_in[7:0] == 8'h21) |=>
      acc_a == $past(acc_a) + long_to_acc($past(x_in)) +
               {{(`AAU_ACC_W-1){1'b0}}, $past(condition_flags_reg[`AAU_FLAG_C])})
      else $error("add with carry sum wrong");
   a_adc_carry_chain: assert property (
      (exec_go && exec_op.kind == KIND_ADD_CARRY && !exec_op.dest_b && !exec_op.src_y &&
       (acc_a[`AAU_MSB:`AAU_LONG_MSB] == '0 || &acc_a[`AAU_MSB:`AAU_LONG_MSB])) |=>
      condition_flags_reg[`AAU_FLAG_C] == $past(chk_c48[`AAU_LONG_W]))
      else $error("add with carry chain carry wrong");
   a_short_imm_add: assert property (
      (instr_ready_out && instr_valid_in && !instr_word_in[`AAU_BIT_D] &&
       ((instr_word_in & `AAU_ADDS_MASK) == `AAU_ADDS_MATCH)) |=>
      acc_a == $past(acc_a) + {26'h0, $past(instr_word_in[`AAU_IMM_HI:`AAU_IMM_LO]), 24'h0})
      else $error("short immediate add wrong");
   a_long_waits_ext: assert property (
      s_issue_long |=> ext_ready_out && !done_out && !instr_ready_out)
      else $error("long immediate did not wait");
   a_long_ext_sum: assert property (
      s_ext_taken_a |=> done_out && acc_a == $past(acc_a) + word_to_acc($past(ext_word_in)))
      else $error("long immediate sum wrong");
   a_acc_src_carry: assert property (
      (exec_go && exec_op.kind == KIND_ADD_REG && !exec_op.dest_b &&
       exec_op.source_selector_field == `AAU_SEL_OTHER) |=>
      condition_flags_reg[`AAU_FLAG_C] == $past(chk_ab[`AAU_ACC_W]))
      else $error("accumulator add carry wrong");
   a_shl_sum_a: assert property (
      (exec_go && exec_op.kind == KIND_SHL_SUM && !exec_op.dest_b) |=>
      acc_a == {$past(acc_a[`AAU_MSB-1:0]), 1'b0} + $past(acc_b) && $stable(acc_b))
      else $error("shift left sum wrong");
   a_shl_ovf_shift: assert property (
      (exec_go && exec_op.kind == KIND_SHL_SUM && (dst[`AAU_MSB] ^ dst[`AAU_MSB-1])) |=>
      condition_flags_reg[`AAU_FLAG_V] && condition_flags_reg[`AAU_FLAG_L])
      else $error("shift overflow not flagged");
   a_dest_b_keeps_a: assert property (
      (exec_go && exec_op.dest_b) |=> $stable(acc_a))
      else $error("wrong accumulator written");
   a_flag_nz: assert property (
      (exec_go && !exec_op.dest_b) |=>
      condition_flags_reg[`AAU_FLAG_Z] == (acc_a == '0) &&
      condition_flags_reg[`AAU_FLAG_N] == acc_a[`AAU_MSB])
      else $error("sign or zero flag wrong");
endmodule : aau_top

// ===== test_accumulator_add_abs_unit.sv
// Purpose: self-checking bench for the accumulator unit
// Assumes: opcodes from aau_core_model, registers over Avalon-MM
// Notes: ea and eb track expected accumulators
`timescale 1ns/1ps
module test_accumulator_add_abs_unit
   import aau_pkg::*;
;
   logic mclk_in = 1'b0;
   logic rst_n_in, iv, ev, ir, er, dn, il, rd, wr, wrq, ok;
   logic [23:0] iw, ew;
   logic [47:0] xv = 48'h8000007fffff, yv = 48'h000000000001;
   logic [4:0] ad;
   logic [31:0] wd, rdata, q;
   logic [7:0] fl;
   logic [55:0] ea, eb, g;
   logic [71:0] h;
   int n_errors = 0;
   int checks_done = 0;
   aau_top aau_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_valid_in(iv),
      .instr_word_in(iw), .ext_valid_in(ev), .ext_word_in(ew), .x_in(xv), .y_in(yv),
      .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wrq),
      .instr_ready_out(ir), .ext_ready_out(er), .done_out(dn), .illegal_out(il),
      .flags_out(fl));
   aau_core_model aau_core_model_inst (.mclk_in(mclk_in), .instr_ready_in(ir),
      .ext_ready_in(er), .done_in(dn), .illegal_in(il), .instr_valid_out(iv),
      .instr_word_out(iw), .ext_valid_out(ev), .ext_word_out(ew));
   initial forever #12.5 mclk_in = ~mclk_in;
   task automatic give_verdict;
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      checks_done++;
      if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      if (got !== exp) n_errors++;
   endtask : chk
   task automatic timeout;
      chk(56'h0, 56'h1);
      give_verdict;
   endtask : timeout
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_in);
      {ad, wr, rd, wd} <= {a, w, ~w, d};
      n = 0;
      @(posedge mclk_in);
      while (wrq !== 1'b0 && n < 50) begin
         @(posedge mclk_in);
         n++;
      end
      q = rdata;
      {rd, wr} <= 2'b00;
      if (n == 50) timeout;
   endtask : bus
   task automatic set_acc(input logic d, input logic [55:0] v);
      for (int k = 0; k < 3; k++)
         bus(1'b1, 5'(12 * d + 4 * k), 32'((v >> (24 * k)) & 56'hffffff));
   endtask : set_acc
   task automatic chk_acc(input logic d, input logic [55:0] v);
      for (int k = 0; k < 3; k++) begin
         bus(1'b0, 5'(12 * d + 4 * k), 32'h0);
         h = {q[23:0], h[71:24]};
      end
      chk(h[55:0], v);
   endtask : chk_acc
   task automatic run(input logic [23:0] w, input logic [23:0] e);
      aau_core_model_inst.issue(w, e, ok);
      if (ok !== 1'b1) timeout;
   endtask : run
   function automatic logic [55:0] src(input logic [2:0] s, input logic d);
      logic [47:0] r;
      logic [23:0] w;
      r = s[0] ? yv : xv;
      w = s[1] ? r[47:24] : r[23:0];
      if (s == 3'h1) return d ? ea : eb;
      return s[2] ? {{8{w[23]}}, w, 24'h0} : {{8{r[47]}}, r};
   endfunction : src
   initial begin
      {rst_n_in, rd, wr, ad, wd} = '0;
      repeat (20) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      ea = 56'hfffffffffffffb;
      eb = '1;
      set_acc(1'b0, ea);
      set_acc(1'b1, eb);
      bus(1'b1, 5'h18, 32'h1);
      run(24'h5a5a26, 24'h0);
      run(24'h000039, 24'h0);
      ea = 56'h5;
      eb = eb + src(3'h3, 1'b1) + 56'h1;
      chk_acc(1'b0, ea);
      chk_acc(1'b1, eb);
      chk(56'(fl[0]), 56'h1);
      run(24'h000021, 24'h0);
      ea = ea + src(3'h2, 1'b0) + 56'h1;
      chk(56'(fl[0]), 56'h0);
      for (int s = 1; s < 8; s++) begin
         g = src(3'(s), s[0]);
         run({17'h0, 3'(s), s[0], 3'h0}, 24'h0);
         {ea, eb} = s[0] ? {ea, eb + g} : {ea + g, eb};
      end
      run(24'h000010, 24'h0);
      h[56:0] = {1'b0, ea} + {1'b0, eb};
      ea = h[55:0];
      chk(56'(fl[0]), 56'(h[56]));
      chk_acc(1'b0, ea);
      chk_acc(1'b1, eb);
      run(24'h017f88, 24'h0);
      run(24'h014580, 24'h0);
      ea = ea + {8'h0, 24'h000005, 24'h0};
      run(24'h0140c0, 24'h800000);
      eb = eb + {8'h0, 24'h00003f, 24'h0};
      ea = ea + {8'hff, 24'h800000, 24'h0};
      chk_acc(1'b0, ea);
      chk_acc(1'b1, eb);
      ea = 56'h40000000000000;
      set_acc(1'b0, ea);
      run(24'h000012, 24'h0);
      ea = (ea << 1) + eb;
      chk(56'(fl[1]), 56'h1);
      run(24'h000000, 24'h0);
      bus(1'b0, 5'h1c, 32'h0);
      chk(56'(q), 56'h2);
      chk_acc(1'b0, ea);
      chk_acc(1'b1, eb);
      give_verdict;
   end
endmodule : test_accumulator_add_abs_unit
